/* File: sqm_regs.vh */
/*
 * Register map, field positions and reset values of the switch
 * queue and mirror configuration bank.
 * Assumes word-indexed registers, byte address = 4 * index.
 */
`ifndef SQM_REGS_VH
`define SQM_REGS_VH

// Register indices (byte address is four times the index)
`define SQM_IDX_PORT_STATE 14'h1840
`define SQM_IDX_PRI_QUEUE 14'h1845
`define SQM_IDX_MIRROR 14'h1846
`define SQM_IDX_INGRESS_TYPE 14'h1847
`define SQM_IDX_IRQ_STATUS 14'h1850
`define SQM_IDX_IRQ_MASK 14'h1851

// Writable bits of each register
`define SQM_PORT_STATE_BITS 32'h0000_003F
`define SQM_PRI_QUEUE_BITS 32'h0000_FFFF
`define SQM_MIRROR_BITS 32'h0000_01FF
`define SQM_INGRESS_TYPE_BITS 32'h0000_003F
`define SQM_IRQ_BITS 32'h0000_0007

// Reset values
`define SQM_PORT_STATE_RST 6'h00
`define SQM_PRI_QUEUE_RST 16'hFA41
`define SQM_MIRROR_RST 9'h000
`define SQM_INGRESS_TYPE_RST 6'h00

// Port mirroring fields
`define SQM_MIR_TX_EN 0
`define SQM_MIR_RX_EN 1
`define SQM_MIR_PORTS_LO 2
`define SQM_MIR_PORTS_HI 4
`define SQM_MIR_SNIFF_LO 5
`define SQM_MIR_SNIFF_HI 7
`define SQM_MIR_FILT_EN 8

// Spanning-tree state encodings
`define SQM_STP_FORWARD 2'h0
`define SQM_STP_BLOCK 2'h1
`define SQM_STP_LEARN 2'h2
`define SQM_STP_DISABLE 2'h3

// Ingress type value that lets the VLAN tag pick the destination
`define SQM_ITYPE_TAG_DEST 2'h3

// Interrupt status bits
`define SQM_IRQ_DROP 0
`define SQM_IRQ_RX_MIR 1
`define SQM_IRQ_TX_MIR 2

`endif

/* File: sqm_tc_lookup.v */
/*
 * Traffic-class lookup: picks a two-bit egress queue from the
 * eight-entry priority map.
 * Assumes the priority is a stable three-bit value.
 */
`timescale 1ns/1ps

module sqm_tc_lookup (
  input wire [15:0] tc_map,
  input wire [2:0] pri,
  output reg [1:0] queue
);

  // Entry n sits at bits 2n+1:2n, priority 7 at the top
  always @* begin
    case (pri)
      3'h0: queue = tc_map[1:0];
      3'h1: queue = tc_map[3:2];
      3'h2: queue = tc_map[5:4];
      3'h3: queue = tc_map[7:6];
      3'h4: queue = tc_map[9:8];
      3'h5: queue = tc_map[11:10];
      3'h6: queue = tc_map[13:12];
      default: queue = tc_map[15:14];
    endcase
  end

endmodule // sqm_tc_lookup

/* File: sqm_mirror.v */
/*
 * Mirror decision: adds the sniffer port to the destinations of
 * mirrored receive and transmit traffic.
 * Assumes one-hot port vectors, bit n for switch port n.
 */
`timescale 1ns/1ps

module sqm_mirror (
  input wire [2:0] rx_port_oh,
  input wire rx_filtered,
  input wire [2:0] rx_base_dest,
  input wire [2:0] tx_port_oh,
  input wire [2:0] mirrored,
  input wire [2:0] sniffer,
  input wire rx_mir_en,
  input wire tx_mir_en,
  input wire filt_mir_en,
  output reg [2:0] rx_dest,
  output reg rx_mirrored,
  output reg [2:0] tx_dest
);

  reg rx_hit;

  // Filtered packets reach only the sniffer, and only if allowed
  always @* begin
    rx_hit = rx_mir_en && ((rx_port_oh & mirrored) != 3'h0);
    if (rx_filtered) begin
      rx_mirrored = rx_hit && filt_mir_en;
      rx_dest = rx_mirrored ? sniffer : 3'h0;
    end else begin
      rx_mirrored = rx_hit;
      rx_dest = rx_base_dest | (rx_hit ? sniffer : 3'h0);
    end
    if (tx_mir_en && ((tx_port_oh & mirrored) != 3'h0)) begin
      tx_dest = sniffer;
    end else begin
      tx_dest = 3'h0;
    end
  end

endmodule // sqm_mirror

/* File: sqm_config.v */
/*
 * Switch queue and mirror configuration bank: Wishbone register
 * slave plus the per-packet decisions that these registers steer
 * (spanning-tree gating, traffic class, mirroring, tag routing).
 * Assumes packet descriptors arrive as one-cycle strobes from the
 * ingress classifier and the egress scheduler, synchronous to clk.
 */
// The implementer's own choice: register access over Wishbone.
// Behaviour
// - Two-bit spanning-tree state per port
// - Eight-entry priority to queue table
// - Table resets to 3,3,2,2,1,0,0,1
// - Sniffer select at bits 7:5
// - Mirrored port mask at bits 4:2
// - Bit 1 mirrors received packets
// - Bit 0 mirrors transmitted packets
// - Bit 8 also mirrors filtered received packets
// - Mirrored filtered packets still count, drop
// - Ingress type 11b routes by tag
// - Mirror and type fields reset zero
`timescale 1ns/1ps
`include "sqm_regs.vh"

module sqm_config (
  input wire clk,
  input wire sys_rst,
  // Wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [15:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // Received packet descriptor
  input wire rx_valid,
  input wire [1:0] rx_port,
  input wire [2:0] rx_pri,
  input wire rx_filtered,
  input wire [2:0] rx_dest,
  input wire [2:0] rx_tag_dest,
  // Transmitted packet notice
  input wire tx_valid,
  input wire [1:0] tx_port,
  // Forwarding decision
  output reg fwd_valid,
  output reg [2:0] fwd_dest,
  output reg [1:0] fwd_queue,
  output reg fwd_learn,
  output reg fwd_dropped,
  // Extra copy of a transmitted packet
  output reg tx_copy_valid,
  output reg [2:0] tx_copy_dest,
  // Filtered counter increments and drop interrupt event
  output reg [2:0] filt_cnt_inc,
  output reg drop_evt,
  output reg irq
);

  // Configuration registers
  reg [5:0] port_state_q;
  reg [15:0] priority_queue_map_q;
  reg [8:0] port_mirror_control_q;
  reg [5:0] ingress_port_type_q;
  reg [2:0] irq_status_q;
  reg [2:0] irq_mask_q;

  // Bus decode
  wire [13:0] word_idx;
  wire bus_req;
  wire wr_stb;
  wire [31:0] be_mask;
  reg [31:0] rd_data_d;

  // Per-port decode of the configuration
  wire [2:0] fwd_ok;
  wire [2:0] learn_ok;
  wire [2:0] tag_route;
  wire [2:0] mirrored;
  wire [2:0] sniffer;

  // Datapath intermediates
  reg [2:0] rx_port_oh;
  reg [2:0] tx_port_oh;
  reg rx_drop;
  reg [2:0] base_dest;
  wire [2:0] mir_rx_dest;
  wire mir_rx_hit;
  wire [2:0] mir_tx_dest;
  wire [1:0] tc_queue;
  wire [2:0] irq_evt;

  // Merged write words; only the low bits of each are kept
  wire [31:0] port_state_wr;
  wire [31:0] pri_queue_wr;
  wire [31:0] mirror_wr;
  wire [31:0] ingress_type_wr;
  wire [31:0] irq_mask_wr;

  assign word_idx = wb_adr_i[15:2];
  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // A write lands on the edge at which the master sees ack, the same
  // edge at which it lets go of the request
  assign wr_stb = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;

  // Byte lanes that a write may touch
  assign be_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                    {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  assign mirrored =
    port_mirror_control_q[`SQM_MIR_PORTS_HI:`SQM_MIR_PORTS_LO];
  assign sniffer =
    port_mirror_control_q[`SQM_MIR_SNIFF_HI:`SQM_MIR_SNIFF_LO];

  // Merge a bus write into a register under the byte lanes
  function [31:0] merge;
    input [31:0] old_val;
    input [31:0] new_val;
    input [31:0] lanes;
    input [31:0] bits;
    begin
      merge = (old_val & ~(lanes & bits)) | (new_val & lanes & bits);
    end
  endfunction

  // Merged words for each writable register; the high bits are cut
  // off where they are stored, so reserved bits always read zero
  assign port_state_wr = merge({26'h0, port_state_q}, wb_dat_i, be_mask,
    `SQM_PORT_STATE_BITS);
  assign pri_queue_wr = merge({16'h0, priority_queue_map_q}, wb_dat_i,
    be_mask, `SQM_PRI_QUEUE_BITS);
  assign mirror_wr = merge({23'h0, port_mirror_control_q}, wb_dat_i,
    be_mask, `SQM_MIRROR_BITS);
  assign ingress_type_wr = merge({26'h0, ingress_port_type_q}, wb_dat_i,
    be_mask, `SQM_INGRESS_TYPE_BITS);
  assign irq_mask_wr = merge({29'h0, irq_mask_q}, wb_dat_i, be_mask,
    `SQM_IRQ_BITS);

  // Per-port decode of state and ingress type
  genvar gp;
  generate
    for (gp = 0; gp < 3; gp = gp + 1) begin : g_port
      assign fwd_ok[gp] =
        port_state_q[2*gp+1:2*gp] == `SQM_STP_FORWARD;
      assign learn_ok[gp] =
        fwd_ok[gp] || port_state_q[2*gp+1:2*gp] == `SQM_STP_LEARN;
      assign tag_route[gp] =
        ingress_port_type_q[2*gp+1:2*gp] == `SQM_ITYPE_TAG_DEST;
    end
  endgenerate

  // Port numbers to one-hot; port number 3 matches nothing
  always @* begin
    rx_port_oh = 3'h0;
    tx_port_oh = 3'h0;
    if (rx_port != 2'h3) begin
      rx_port_oh[rx_port] = 1'b1;
    end
    if (tx_port != 2'h3) begin
      tx_port_oh[tx_port] = 1'b1;
    end
  end

  // Normal destination before mirroring is added
  always @* begin
    rx_drop = rx_filtered || ((rx_port_oh & fwd_ok) == 3'h0);
    if ((rx_port_oh & tag_route) != 3'h0) begin
      base_dest = rx_tag_dest;
    end else begin
      base_dest = rx_dest;
    end
    // egress gating, never back out the ingress port
    base_dest = base_dest & fwd_ok & ~rx_port_oh;
  end

  sqm_tc_lookup u_tc (
    .tc_map(priority_queue_map_q),
    .pri(rx_pri),
    .queue(tc_queue)
  );

  // Mirror copies; a sniffer left at zero simply drops the copy
  sqm_mirror u_mir (
    .rx_port_oh(rx_port_oh),
    .rx_filtered(rx_drop),
    .rx_base_dest(base_dest),
    .tx_port_oh(tx_port_oh),
    .mirrored(mirrored),
    .sniffer(sniffer),
    .rx_mir_en(port_mirror_control_q[`SQM_MIR_RX_EN]),
    .tx_mir_en(port_mirror_control_q[`SQM_MIR_TX_EN]),
    .filt_mir_en(port_mirror_control_q[`SQM_MIR_FILT_EN]),
    .rx_dest(mir_rx_dest),
    .rx_mirrored(mir_rx_hit),
    .tx_dest(mir_tx_dest)
  );

  // Forwarding decision, one cycle after the descriptor
  always @(posedge clk) begin
    if (sys_rst) begin
      fwd_valid <= 1'b0;
      fwd_dest <= 3'h0;
      fwd_queue <= 2'h0;
      fwd_learn <= 1'b0;
      fwd_dropped <= 1'b0;
    end else begin
      fwd_valid <= rx_valid;
      fwd_dest <= rx_valid ? mir_rx_dest : 3'h0;
      fwd_queue <= tc_queue;
      fwd_learn <= rx_valid && ((rx_port_oh & learn_ok) != 3'h0);
      fwd_dropped <= rx_valid && rx_drop;
    end
  end

  // Transmit mirroring copy request
  always @(posedge clk) begin
    if (sys_rst) begin
      tx_copy_valid <= 1'b0;
      tx_copy_dest <= 3'h0;
    end else begin
      tx_copy_valid <= tx_valid && (mir_tx_dest != 3'h0);
      tx_copy_dest <= tx_valid ? mir_tx_dest : 3'h0;
    end
  end

  // Filtered packets are counted even when sent to the sniffer
  always @(posedge clk) begin
    if (sys_rst) begin
      filt_cnt_inc <= 3'h0;
      drop_evt <= 1'b0;
    end else begin
      filt_cnt_inc <= (rx_valid && rx_drop) ? rx_port_oh : 3'h0;
      drop_evt <= rx_valid && rx_drop;
    end
  end

  // Interrupt events, taken from the same cycle as the decision
  // A transmit mirror event needs a sniffer bit; a receive mirror event does not
  assign irq_evt = {tx_valid && (mir_tx_dest != 3'h0),
                    rx_valid && mir_rx_hit,
                    rx_valid && rx_drop};

  // Sticky status, write one to clear; a new event beats the clear
  always @(posedge clk) begin
    if (sys_rst) begin
      irq_status_q <= 3'h0;
    end else if (wr_stb && word_idx == `SQM_IDX_IRQ_STATUS) begin
      irq_status_q <= (irq_status_q & ~(wb_dat_i[2:0] & be_mask[2:0]))
                      | irq_evt;
    end else begin
      irq_status_q <= irq_status_q | irq_evt;
    end
  end

  // Level interrupt from unmasked status bits
  always @(posedge clk) begin
    if (sys_rst) begin
      irq <= 1'b0;
    end else begin
      irq <= (irq_status_q & irq_mask_q) != 3'h0;
    end
  end

  // Register writes, committed on the edge at which ack is seen high
  always @(posedge clk) begin
    if (sys_rst) begin
      port_state_q <= `SQM_PORT_STATE_RST;
      priority_queue_map_q <= `SQM_PRI_QUEUE_RST;
      port_mirror_control_q <= `SQM_MIRROR_RST;
      ingress_port_type_q <= `SQM_INGRESS_TYPE_RST;
      irq_mask_q <= 3'h0;
    end else if (wr_stb) begin
      case (word_idx)
        `SQM_IDX_PORT_STATE: begin
          port_state_q <= port_state_wr[5:0];
        end
        `SQM_IDX_PRI_QUEUE: begin
          priority_queue_map_q <= pri_queue_wr[15:0];
        end
        `SQM_IDX_MIRROR: begin
          port_mirror_control_q <= mirror_wr[8:0];
        end
        `SQM_IDX_INGRESS_TYPE: begin
          ingress_port_type_q <= ingress_type_wr[5:0];
        end
        `SQM_IDX_IRQ_MASK: begin
          irq_mask_q <= irq_mask_wr[2:0];
        end
        // Unmapped words and the status word take no plain write
        default: begin
          port_state_q <= port_state_q;
        end
      endcase
    end
  end

  // Read mux; reserved bits and unmapped words read zero
  always @* begin
    case (word_idx)
      `SQM_IDX_PORT_STATE: rd_data_d = {26'h0, port_state_q};
      `SQM_IDX_PRI_QUEUE: rd_data_d = {16'h0, priority_queue_map_q};
      `SQM_IDX_MIRROR: rd_data_d = {23'h0, port_mirror_control_q};
      `SQM_IDX_INGRESS_TYPE: rd_data_d = {26'h0, ingress_port_type_q};
      `SQM_IDX_IRQ_STATUS: rd_data_d = {29'h0, irq_status_q};
      `SQM_IDX_IRQ_MASK: rd_data_d = {29'h0, irq_mask_q};
      default: rd_data_d = 32'h0000_0000;
    endcase
  end

  // Single-wait-state ack; every address answers, none stalls the bus
  // Read data is latched as the request is taken and stands with ack
  always @(posedge clk) begin
    if (sys_rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_req;
      if (bus_req && !wb_we_i) begin
        wb_dat_o <= rd_data_d;
      end
    end
  end

endmodule // sqm_config

/* File: sqm_config_properties.sv */
/* Checker for sqm_config: bus answer, forwarding and copy timing.
   Assumes it is bound to every sqm_config instance. */
`timescale 1ns/1ps
module sqm_cfg_props (
  input wire clk,
  input wire sys_rst,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_ack_o,
  input wire rx_valid,
  input wire [1:0] rx_port,
  input wire tx_valid,
  input wire [1:0] tx_port,
  input wire fwd_valid,
  input wire fwd_dropped,
  input wire [2:0] filt_cnt_inc,
  input wire drop_evt,
  input wire tx_copy_valid,
  input wire [2:0] tx_copy_dest,
  input wire irq
);
  // One clock domain, reset masks every check
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_fwd_answer: assert property (rx_valid |=> fwd_valid)
    else $error("no decision after descriptor");
  a_fwd_cause: assert property (!rx_valid |=> !fwd_valid)
    else $error("decision without descriptor");
  a_none_drop: assert property (rx_valid && rx_port == 2'h3 |=> fwd_dropped)
    else $error("packet from no port forwarded");
  a_drop_event: assert property (fwd_valid && fwd_dropped |-> drop_evt)
    else $error("drop without drop event");
  a_drop_count: assert property (fwd_valid && fwd_dropped
    && $past(rx_port) != 2'h3 |-> filt_cnt_inc == 3'h1 << $past(rx_port))
    else $error("filtered count on wrong port");
  a_clean_no_count: assert property (fwd_valid && !fwd_dropped
    |-> filt_cnt_inc == 3'h0 && !drop_evt)
    else $error("count or drop event without a drop");
  a_copy_cause: assert property (!tx_valid |=> !tx_copy_valid)
    else $error("copy without transmit");
  a_copy_sniff: assert property (tx_copy_valid |-> tx_copy_dest != 3'h0)
    else $error("copy with no sniffer");
  a_no_port_copy: assert property (tx_valid && tx_port == 2'h3 |=> !tx_copy_valid)
    else $error("copy for no port");
  a_ack_pulse: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
    |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus answer not one cycle");
  a_reset_quiet: assert property ($fell(sys_rst) |-> !fwd_valid && !irq)
    else $error("outputs busy after reset");
endmodule // sqm_cfg_props

bind sqm_config sqm_cfg_props u_props (.clk, .sys_rst, .wb_cyc_i,
  .wb_stb_i, .wb_ack_o, .rx_valid, .rx_port, .tx_valid, .tx_port,
  .fwd_valid, .fwd_dropped, .filt_cnt_inc, .drop_evt, .tx_copy_valid,
  .tx_copy_dest, .irq);

/* File: tb_sqm_config.sv */
/* Self-checking bench for sqm_config: registers, forwarding,
   mirroring and the interrupt.
   Assumes answers are one cycle after each request. */
`timescale 1ns/1ps
`include "sqm_regs.vh"
module tb_sqm_config;
  logic clk = 0, sys_rst = 1, cyc = 0, stb = 0, we = 0;
  logic [15:0] adr = 0;
  logic [3:0] sel = 0;
  logic [31:0] dat = 0, rdat, r;
  logic rxv = 0, rxf = 0, txv = 0, ack, fv, fl, fdr, tcv, dev, irq;
  logic [1:0] rxp = 0, txp = 0, fq;
  logic [2:0] pri = 0, rxd = 0, rxt = 3'h4, fd, tcd, fci;
  logic [15:0] tc_map = 16'hFA41;
  logic [31:0] rx_q[$], tx_q[$], rd_q[$];
  int err_total = 0, n_compared = 0, i;

  sqm_config u_dut (.clk(clk), .sys_rst(sys_rst), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .rx_valid(rxv),
    .rx_port(rxp), .rx_pri(pri), .rx_filtered(rxf), .rx_dest(rxd),
    .rx_tag_dest(rxt), .tx_valid(txv), .tx_port(txp), .fwd_valid(fv),
    .fwd_dest(fd), .fwd_queue(fq), .fwd_learn(fl), .fwd_dropped(fdr),
    .tx_copy_valid(tcv), .tx_copy_dest(tcd), .filt_cnt_inc(fci),
    .drop_evt(dev), .irq(irq));

  // 250 MHz clock
  always #2 clk = ~clk;

  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic tally_and_finish;
    $display("compared %0d mismatched %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Hold the request until ack; bounded so a dead slave ends the run
  task automatic bus(logic w, logic [13:0] idx, logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= {idx, 2'b00};
    sel <= 4'hF;
    dat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) begin
      err_total++;
      $display("[FAIL] bus ack expected 1 seen %b", ack);
      tally_and_finish();
    end
    cyc <= 0;
    stb <= 0;
  endtask

  task automatic wr(logic [13:0] idx, logic [31:0] d);
    bus(1, idx, d);
  endtask

  task automatic rd(logic [13:0] idx, logic [31:0] e);
    rd_q.push_back(e);
    bus(0, idx, 0);
  endtask

  // Note: expected dest ed, learn l, dropped dr; queue from tc_map
  task automatic rx(logic [1:0] p, logic [2:0] pr, logic f,
    logic [2:0] d, logic [2:0] ed, logic l, logic dr);
    rx_q.push_back({dr ? 3'h1 << p : 3'h0, dr, ed, tc_map[pr*2 +: 2], l, dr});
    @(posedge clk);
    rxv <= 1;
    rxp <= p;
    pri <= pr;
    rxf <= f;
    rxd <= d;
    @(posedge clk);
    rxv <= 0;
  endtask

  task automatic tx(logic [1:0] p, logic [2:0] ed);
    if (ed != 3'h0) tx_q.push_back(ed);
    @(posedge clk);
    txv <= 1;
    txp <= p;
    @(posedge clk);
    txv <= 0;
  endtask

  // Result watcher: every answer takes the oldest note
  always @(posedge clk) begin
    if (fv) chk("fwd", rx_q.size() ? rx_q.pop_front() : 32'hFFFF_FFFF,
      {fci, dev, fd, fq, fl, fdr});
    if (tcv) chk("copy", tx_q.size() ? tx_q.pop_front() : 32'h0,
      tcd);
    if (ack && !we) chk("read", rd_q.size() ? rd_q.pop_front() : 32'h0,
      rdat);
  end

  initial begin
    i = $urandom(32'h45d8);
    repeat (4) @(posedge clk);
    sys_rst <= 0;
    rd(`SQM_IDX_PRI_QUEUE, 32'h0000_FA41);
    rd(`SQM_IDX_MIRROR, 0);
    rd(`SQM_IDX_INGRESS_TYPE, 0);
    rd(14'h1848, 0);
    for (i = 0; i < 8; i++) rx(0, i, 0, 3'h6, 3'h6, 1, 0);
    r = $urandom;
    r[7:6] = 2'h0;
    wr(`SQM_IDX_MIRROR, r);
    rd(`SQM_IDX_MIRROR, r & `SQM_MIRROR_BITS);
    wr(`SQM_IDX_INGRESS_TYPE, r);
    rd(`SQM_IDX_INGRESS_TYPE, r & `SQM_INGRESS_TYPE_BITS);
    wr(`SQM_IDX_PRI_QUEUE, r);
    rd(`SQM_IDX_PRI_QUEUE, r & `SQM_PRI_QUEUE_BITS);
    tc_map = r[15:0];
    wr(`SQM_IDX_MIRROR, 0);
    wr(`SQM_IDX_INGRESS_TYPE, 0);
    for (i = 0; i < 8; i++) rx(0, i, 0, 3'h6, 3'h6, 1, 0);
    // Every spanning-tree state on the ingress port
    for (i = 0; i < 4; i++) begin
      wr(`SQM_IDX_PORT_STATE, i);
      rx(0, 3, 0, 3'h6, i ? 3'h0 : 3'h6, !i[0], i != 0);
    end
    // Port 2 disabled: never a destination
    wr(`SQM_IDX_PORT_STATE, 32'h0000_0030);
    rx(0, 3, 0, 3'h6, 3'h2, 1, 0);
    wr(`SQM_IDX_PORT_STATE, 0);
    // Port number 3 is no port: dropped, never learnt
    rx(3, 0, 0, 3'h3, 3'h0, 0, 1);
    for (i = 0; i < 4; i++) begin
      wr(`SQM_IDX_INGRESS_TYPE, i);
      rx(0, 1, 0, 3'h2, i == 3 ? 3'h4 : 3'h2, 1, 0);
    end
    wr(`SQM_IDX_INGRESS_TYPE, 0);
    // Sniffer 2, port 0 mirrored both ways
    wr(`SQM_IDX_MIRROR, 32'h0000_0087);
    rx(0, 0, 0, 3'h2, 3'h6, 1, 0);
    rx(1, 0, 0, 3'h1, 3'h1, 1, 0);
    rx(0, 0, 1, 3'h2, 3'h0, 1, 1);
    tx(0, 3'h4);
    tx(1, 3'h0);
    wr(`SQM_IDX_MIRROR, 32'h0000_0187);
    rx(0, 0, 1, 3'h2, 3'h4, 1, 1);
    wr(`SQM_IDX_MIRROR, 32'h0000_0045);
    rx(0, 0, 0, 3'h4, 3'h4, 1, 0);
    tx(0, 3'h2);
    wr(`SQM_IDX_MIRROR, 32'h0000_0031);
    tx(2, 3'h1);
    tx(0, 3'h0);
    tx(3, 3'h0);
    // Drop interrupt: raise, mask, unmask, clear
    wr(`SQM_IDX_MIRROR, 0);
    wr(`SQM_IDX_IRQ_STATUS, 32'h0000_0007);
    wr(`SQM_IDX_IRQ_MASK, 32'h0000_0001);
    rx(1, 0, 1, 3'h1, 3'h0, 1, 1);
    repeat (2) @(posedge clk);
    chk("irq set", 1, irq);
    rd(`SQM_IDX_IRQ_STATUS, 32'h0000_0001);
    wr(`SQM_IDX_IRQ_MASK, 0);
    repeat (2) @(posedge clk);
    chk("irq masked", 0, irq);
    wr(`SQM_IDX_IRQ_MASK, 32'h0000_0001);
    repeat (2) @(posedge clk);
    chk("irq unmasked", 1, irq);
    wr(`SQM_IDX_IRQ_STATUS, 32'h0000_0001);
    repeat (2) @(posedge clk);
    chk("irq cleared", 0, irq);
    repeat (4) @(posedge clk);
    chk("left", 0, rx_q.size() + tx_q.size() + rd_q.size());
    tally_and_finish();
  end
endmodule // tb_sqm_config
